// [bench/pld_powerdown_hold_logic_test.sv]
`timescale 1ns/1ps
module pld_powerdown_hold_logic_test;
  import pldpd_pkg::*;
  logic clk_i, rst_n_i, read_i, write_i, waitrequest_o, sleeping_o, shared, sleep_set;
  logic [10:0] ded_set, ded_in;
  logic [9:0] io_in, io_out_o, io_oe_n_o;
  logic [8:0] address_i;
  logic [31:0] writedata_i, readdata_o, rd;
  int errors, n_tests;
  pldpd_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .ded_in_i(ded_in),
    .shared_input_sleep_pin_i(shared), .io_in_i(io_in), .io_out_o(io_out_o),
    .io_oe_n_o(io_oe_n_o), .sleeping_o(sleeping_o), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
    .waitrequest_o(waitrequest_o));
  pldpd_far far (.clk_i(clk_i), .ded_set_i(ded_set), .sleep_set_i(sleep_set),
    .io_out_i(io_out_o), .io_oe_n_i(io_oe_n_o), .ded_in_o(ded_in), .shared_o(shared),
    .io_in_o(io_in));
  initial
  begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [8:0] a, input logic [31:0] d);
    int n;
    n = 0;
    read_i <= !wr;
    write_i <= wr;
    address_i <= a;
    writedata_i <= d;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (waitrequest_o !== 1'b0 && n < 20);
    rd = readdata_o;
    read_i <= 0;
    write_i <= 0;
    @(posedge clk_i);
    if (n >= 20)
    begin
      errors++;
      complete_run();
    end
  endtask : bus
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick
  task automatic t_plain;
    bus(1, ADDR_CFG, 32'h0001_1704);
    for (int m = 0; m < 3; m++)
    begin
      bus(1, 9'h100 + 9'(m * 16), 32'h1);
      bus(1, 9'h102 + 9'(m * 16), m == 1 ? 32'h800 : 32'h2);
    end
    bus(1, ADDR_MCELL, 32'h03FB_0000);
    ded_set <= 11'h003;
    sleep_set <= 1;
    tick(4);
    check("sleep flag", sleeping_o, 0);
    check("outputs", io_out_o[2:0], 3'b011);
    check("enables", io_oe_n_o, 10'h3F8);
    bus(0, ADDR_STATUS, 0);
    check("feature", rd[ST_FEAT_BIT], 0);
    ded_set <= 11'h001;
    sleep_set <= 0;
    tick(4);
    check("outputs low", io_out_o[2:0], 3'b100);
    $display("plain input test done");
  endtask : t_plain
  task automatic t_sleep;
    bus(1, ADDR_CFG, 32'h0001_1705);
    ded_set <= 11'h003;
    tick(4);
    bus(0, ADDR_STATUS, 0);
    check("feature", rd[ST_FEAT_BIT], 1);
    sleep_set <= 1;
    tick(3);
    check("sleep flag", sleeping_o, 1);
    ded_set <= 11'h000;
    tick(4);
    check("held outputs", io_out_o[2:0], 3'b001);
    check("held enables", io_oe_n_o, 10'h3F8);
    sleep_set <= 0;
    tick(4);
    check("awake", sleeping_o, 0);
    check("resumed outputs", io_out_o[2:0], 3'b100);
    bus(0, ADDR_STATUS, 0);
    check("settled", rd[ST_SETTLED_BIT], 1);
    $display("sleep test done");
  endtask : t_sleep
  task automatic t_lock;
    bus(1, ADDR_SIG_LO, 32'hA5A5_0F0F);
    bus(1, ADDR_SIG_HI, 32'h1234_5678);
    bus(1, ADDR_CFG, 32'h8001_1705);
    bus(0, ADDR_CFG, 0);
    check("locked cfg", rd & 32'h0001_FFFF, 0);
    bus(0, 9'h100, 0);
    check("locked term", rd, 0);
    bus(0, ADDR_SIG_LO, 0);
    check("sig lo", rd, 32'hA5A5_0F0F);
    bus(0, ADDR_SIG_HI, 0);
    check("sig hi", rd, 32'h1234_5678);
    bus(0, 9'h006, 0);
    check("unmapped", rd, 0);
    rst_n_i <= 0;
    tick(2);
    rst_n_i <= 1;
    tick(1);
    check("enables after reset", io_oe_n_o, 10'h3FF);
    bus(0, ADDR_CFG, 0);
    check("lock cleared", rd, 0);
    $display("lock test done");
  endtask : t_lock
  initial
  begin
    errors = 0;
    n_tests = 0;
    rst_n_i = 0;
    read_i = 0;
    write_i = 0;
    address_i = 0;
    writedata_i = 0;
    ded_set = 0;
    sleep_set = 0;
    tick(5);
    rst_n_i <= 1;
    tick(1);
    check("reset enables", io_oe_n_o, 10'h3FF);
    t_plain();
    t_sleep();
    t_lock();
    complete_run();
  end
endmodule : pld_powerdown_hold_logic_test

// [bench/pldpd_assertions.sv]
`timescale 1ns/1ps
module pldpd_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic shared_input_sleep_pin_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [9:0] io_out_o,
  input wire logic [9:0] io_oe_n_o,
  input wire logic sleeping_o,
  input wire logic waitrequest_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  chk_sleep_cause: assert property ($rose(sleeping_o) |-> $past(shared_input_sleep_pin_i))
    else $error("sleep entered without pin high");
  chk_sleep_exit: assert property (sleeping_o && !shared_input_sleep_pin_i |=> !sleeping_o)
    else $error("sleep not left after pin low");
  chk_wake_cause: assert property ($fell(sleeping_o) && $past(rst_n_i)
    |-> !$past(shared_input_sleep_pin_i))
    else $error("sleep left while pin high");
  chk_entry_frozen: assert property ($rose(sleeping_o) |-> $stable(io_out_o))
    else $error("outputs updated on sleep entry");
  chk_out_held: assert property (sleeping_o && shared_input_sleep_pin_i |=> $stable(io_out_o))
    else $error("outputs changed while asleep");
  chk_oe_held: assert property (sleeping_o && shared_input_sleep_pin_i |=> $stable(io_oe_n_o))
    else $error("enables changed while asleep");
  chk_inputs_blocked: assert property ((sleeping_o && shared_input_sleep_pin_i) [*2]
    |=> io_out_o == $past(io_out_o, 2))
    else $error("inputs reached logic while asleep");
  chk_bus_answer: assert property ((read_i || write_i) && waitrequest_o |=> !waitrequest_o)
    else $error("bus answer late");
  chk_bus_pulse: assert property (!waitrequest_o |=> waitrequest_o)
    else $error("bus answer held too long");
endmodule : pldpd_checker
bind pldpd_core pldpd_checker chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .shared_input_sleep_pin_i(shared_input_sleep_pin_i), .read_i(read_i), .write_i(write_i),
  .io_out_o(io_out_o), .io_oe_n_o(io_oe_n_o), .sleeping_o(sleeping_o),
  .waitrequest_o(waitrequest_o));

// [bench/pldpd_far.sv]
`timescale 1ns/1ps
module pldpd_far (
  // stimulus from bench
  input wire logic clk_i,
  input wire logic [10:0] ded_set_i,
  input wire logic sleep_set_i,
  // device pins
  input wire logic [9:0] io_out_i,
  input wire logic [9:0] io_oe_n_i,
  output logic [10:0] ded_in_o,
  output logic shared_o,
  output logic [9:0] io_in_o
);
  logic [9:0] keep_q = '0;
  assign ded_in_o = ded_set_i;
  assign shared_o = sleep_set_i;
  // undriven pins keep their last level
  always_ff @(posedge clk_i)
    keep_q <= io_in_o;
  always_comb
    for (int k = 0; k < 10; k++)
      io_in_o[k] = io_oe_n_i[k] ? keep_q[k] : io_out_i[k];
endmodule : pldpd_far

// [verilog/pldpd_core.sv]
`timescale 1ns/1ps
// Summary of operation
// - enabled option plus sleep pin high puts the device into hold state
// - on entry io outputs, enables, macrocell registers and pin hold latches are held
// - outputs in an undetermined state keep that same state while asleep
// - while asleep all inputs except the sleep pin are ignored
// - input and io hold latches stay active so no pin floats
// - one dedicated configuration bit selects the sleep function
// - option off: shared pin is an ordinary array input
// - option on: shared pin does not feed the array
// - option on: macrocell feedback and foldback terms remain usable
// - only the sleep variant fuse count enables the feature
// - twelve inputs and ten bidirectional macrocells share one term array
// - each macrocell is registered or combinational, active high or low
// - once locked, configuration contents read back as zero, except the lock bit itself
// - 64-bit user signature stays readable even when locked
module pldpd_core
  import pldpd_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // device pins
  input wire logic [pldpd_pkg::N_IN-2:0] ded_in_i,
  input wire logic shared_input_sleep_pin_i,
  input wire logic [pldpd_pkg::N_MC-1:0] io_in_i,
  output logic [pldpd_pkg::N_MC-1:0] io_out_o,
  output logic [pldpd_pkg::N_MC-1:0] io_oe_n_o,
  output logic sleeping_o,
  // avalon-mm slave
  input wire logic [pldpd_pkg::ADDR_W-1:0] address_i,
  input wire logic read_i,
  input wire logic write_i,
  input wire logic [31:0] writedata_i,
  output logic [31:0] readdata_o,
  output logic waitrequest_o
);
  import pldpd_pkg::*;

  pldpd_state_t s_reg;
  pldpd_state_t s_next;
  logic [ARR_W-1:0] term_mem [0:MEM_DEPTH-1];
  logic [ARR_W-1:0] arr_vec;
  logic [N_MC-1:0] sop;
  logic [N_MC-1:0] oe_term;
  logic [N_MC-1:0] fb;
  logic feature_on;
  logic sleeping;
  logic in_term_range;
  logic bus_req;
  logic bus_done;
  logic [N_IN-1:0] array_in;

  assign feature_on = (s_reg.fuse_cnt == FUSES_SLEEP) && s_reg.sleep_fuse;
  assign sleeping = feature_on && shared_input_sleep_pin_i;
  assign in_term_range = (address_i >= ADDR_TERM_FIRST) && (address_i <= ADDR_TERM_LAST);
  assign bus_req = read_i || write_i;
  assign bus_done = bus_req && !s_reg.wait_req;

  // feedback: register output when registered, held pin level otherwise
  assign fb = (s_reg.reg_sel & s_reg.mc_q) | (~s_reg.reg_sel & s_reg.io_hold);

  always_comb
  begin
    array_in = s_reg.in_hold;
    if (feature_on)
    begin
      array_in[SHARED_IDX] = 1'b0;
    end
  end

  // array sees held pins only, feedback is never gated by the option
  assign arr_vec = {fb, array_in};

  // product terms: even word true mask, odd word complement mask, term 0 drives oe
  for (genvar m = 0; m < N_MC; m++)
  begin : g_mc
    logic [N_TERM-1:0] term;
    always_comb
    begin
      for (int t = 0; t < N_TERM; t++)
      begin
        term[t] = (|{term_mem[m * MC_STRIDE + 2 * t], term_mem[m * MC_STRIDE + 2 * t + 1]})
          && (&((~term_mem[m * MC_STRIDE + 2 * t] | arr_vec)
          & (~term_mem[m * MC_STRIDE + 2 * t + 1] | ~arr_vec)));
      end
    end
    assign oe_term[m] = term[0];
    assign sop[m] = |term[N_TERM-1:1];
  end

  always_comb
  begin
    s_next = s_reg;
    s_next.sleep = sleeping;
    if (!sleeping)
    begin
      // hold latches track pins only while awake
      s_next.in_hold = {shared_input_sleep_pin_i, ded_in_i};
      s_next.io_hold = io_in_i;
      s_next.mc_q = sop;
      s_next.io_out = sop ^ ~s_reg.pol_high;
      s_next.io_oe_n = ~oe_term;
    end
    // else every pin-facing field keeps its value, known or not
    if (sleeping)
    begin
      s_next.wake_cnt = WAKE_CYC;
    end
    else if (s_reg.wake_cnt != 4'h0)
    begin
      s_next.wake_cnt = s_reg.wake_cnt - 4'h1;
    end
    // bus: one wait cycle, then answer
    s_next.wait_req = !(bus_req && s_reg.wait_req);
    if (read_i && s_reg.wait_req)
    begin
      s_next.rdata = 32'h0000_0000;
      if (address_i == ADDR_CFG)
      begin
        if (!s_reg.lock)
        begin
          s_next.rdata[CFG_FUSE_LSB +: CFG_FUSE_W] = s_reg.fuse_cnt;
          s_next.rdata[CFG_SLEEP_BIT] = s_reg.sleep_fuse;
        end
        s_next.rdata[CFG_LOCK_BIT] = s_reg.lock;
      end
      else if (address_i == ADDR_MCELL)
      begin
        if (!s_reg.lock)
        begin
          s_next.rdata[MCELL_REG_LSB +: N_MC] = s_reg.reg_sel;
          s_next.rdata[MCELL_POL_LSB +: N_MC] = s_reg.pol_high;
        end
      end
      else if (address_i == ADDR_STATUS)
      begin
        s_next.rdata[ST_SLEEP_BIT] = s_reg.sleep;
        s_next.rdata[ST_FEAT_BIT] = feature_on;
        s_next.rdata[ST_LOCK_BIT] = s_reg.lock;
        s_next.rdata[ST_SETTLED_BIT] = !s_reg.sleep && (s_reg.wake_cnt == 4'h0);
      end
      else if (address_i == ADDR_SIG_LO)
      begin
        s_next.rdata = s_reg.sig[31:0];
      end
      else if (address_i == ADDR_SIG_HI)
      begin
        s_next.rdata = s_reg.sig[63:32];
      end
      else if (address_i == ADDR_PINS)
      begin
        s_next.rdata[N_IN-1:0] = s_reg.in_hold;
        s_next.rdata[16 +: N_MC] = s_reg.io_hold;
      end
      else if (in_term_range && !s_reg.lock)
      begin
        s_next.rdata[ARR_W-1:0] = term_mem[address_i[7:0]];
      end
    end
    if (write_i && bus_done)
    begin
      if (address_i == ADDR_CFG)
      begin
        if (!s_reg.lock)
        begin
          s_next.fuse_cnt = writedata_i[CFG_FUSE_LSB +: CFG_FUSE_W];
          s_next.sleep_fuse = writedata_i[CFG_SLEEP_BIT];
        end
        s_next.lock = s_reg.lock || writedata_i[CFG_LOCK_BIT];
      end
      else if (address_i == ADDR_MCELL && !s_reg.lock)
      begin
        s_next.reg_sel = writedata_i[MCELL_REG_LSB +: N_MC];
        s_next.pol_high = writedata_i[MCELL_POL_LSB +: N_MC];
      end
      else if (address_i == ADDR_SIG_LO)
      begin
        s_next.sig[31:0] = writedata_i;
      end
      else if (address_i == ADDR_SIG_HI)
      begin
        s_next.sig[63:32] = writedata_i;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s_reg <= '0;
      s_reg.io_oe_n <= '1;
      s_reg.wait_req <= 1'b1;
      s_reg.pol_high <= '1;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // term store, locked contents cannot be rewritten until reset
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < MEM_DEPTH; i++)
      begin
        term_mem[i] <= '0;
      end
    end
    else if (write_i && bus_done && in_term_range && !s_reg.lock)
    begin
      term_mem[address_i[7:0]] <= writedata_i[ARR_W-1:0];
    end
  end

  assign io_out_o = s_reg.io_out;
  assign io_oe_n_o = s_reg.io_oe_n;
  assign sleeping_o = s_reg.sleep;
  assign readdata_o = s_reg.rdata;
  assign waitrequest_o = s_reg.wait_req;
endmodule : pldpd_core

// [verilog/pldpd_pkg.sv]
package pldpd_pkg;
  localparam int unsigned N_IN = 12;
  localparam int unsigned N_MC = 10;
  localparam int unsigned N_TERM = 8;
  localparam int unsigned ARR_W = N_IN + N_MC;
  localparam int unsigned MC_STRIDE = 16;
  localparam int unsigned MEM_DEPTH = N_MC * MC_STRIDE;
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned SIG_W = 64;
  // register word indexes
  localparam logic [8:0] ADDR_CFG = 9'h000;
  localparam logic [8:0] ADDR_MCELL = 9'h001;
  localparam logic [8:0] ADDR_STATUS = 9'h002;
  localparam logic [8:0] ADDR_SIG_LO = 9'h003;
  localparam logic [8:0] ADDR_SIG_HI = 9'h004;
  localparam logic [8:0] ADDR_PINS = 9'h005;
  localparam logic [8:0] ADDR_TERM_FIRST = 9'h100;
  localparam logic [8:0] ADDR_TERM_LAST = 9'h19F;
  // configuration word fields
  localparam int unsigned CFG_FUSE_LSB = 0;
  localparam int unsigned CFG_FUSE_W = 13;
  localparam int unsigned CFG_SLEEP_BIT = 16;
  localparam int unsigned CFG_LOCK_BIT = 31;
  localparam logic [12:0] FUSES_PLAIN = 13'h16C4;
  localparam logic [12:0] FUSES_SIG = 13'h1704;
  localparam logic [12:0] FUSES_SLEEP = 13'h1705;
  // macrocell word fields
  localparam int unsigned MCELL_REG_LSB = 0;
  localparam int unsigned MCELL_POL_LSB = 16;
  // status word fields
  localparam int unsigned ST_SLEEP_BIT = 0;
  localparam int unsigned ST_FEAT_BIT = 1;
  localparam int unsigned ST_LOCK_BIT = 2;
  localparam int unsigned ST_SETTLED_BIT = 3;
  // wake settle time
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned WAKE_SETTLE_NS = 25;
  localparam int unsigned WAKE_CYC_INT = (WAKE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] WAKE_CYC = 4'(WAKE_CYC_INT < 1 ? 1 : WAKE_CYC_INT);
  localparam int unsigned SHARED_IDX = N_IN - 1;

  typedef struct packed {
    logic [N_IN-1:0] in_hold;
    logic [N_MC-1:0] io_hold;
    logic [N_MC-1:0] mc_q;
    logic [N_MC-1:0] io_out;
    logic [N_MC-1:0] io_oe_n;
    logic sleep;
    logic [3:0] wake_cnt;
    logic [12:0] fuse_cnt;
    logic sleep_fuse;
    logic lock;
    logic [N_MC-1:0] reg_sel;
    logic [N_MC-1:0] pol_high;
    logic [SIG_W-1:0] sig;
    logic wait_req;
    logic [31:0] rdata;
  } pldpd_state_t;
endpackage : pldpd_pkg
